// ---- design/dgr_general_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module dgr_general_regs
  import dgr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  // Host I/O bus, same clock domain
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioWr,
  input  wire logic        ioRd,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  output logic             ioRdHit,
  // Board straps and bus mode
  input  wire logic        altBusMode,
  input  wire logic        config_strap_nine,
  input  wire logic        configBitThree,
  // Asynchronous video and pin inputs
  input  wire logic        data_bus_line_fifteen,
  input  wire logic        vRetraceIrq,
  input  wire logic        vRetraceIn,
  input  wire logic        blankingIn,
  input  wire logic [7:0]  vidBitsIn,
  input  wire logic [1:0]  planeDiagSel,
  // Control outputs
  output logic             vsyncNeg,
  output logic             hsyncNeg,
  output logic             pageUpper,
  output logic [1:0]       dotClkSel,
  output logic             hostMemEn,
  output logic             colorIoSel,
  output logic             crtIndexSel,
  output logic             crtDataSel,
  output logic             decodeEn,
  output logic             setupSel
);
  // Two-stage synchronisers for 12 asynchronous bits
  localparam int SW = 12;
  logic [SW-1:0] syncAReg;   // First stage, read only by second
  logic [SW-1:0] syncBReg;   // Second stage, safe to use
  logic [7:0]    miscReg;    // Miscellaneous output register
  logic [7:0]    miscNext;   // Its next value
  logic          decReg;     // Decode enable from port 3C3
  logic          decNext;    // Its next value
  logic [7:0]    rdReg;      // Read data register
  logic [7:0]    rdNext;     // Its next value
  logic          hitReg;     // Read answered flag
  logic          hitNext;    // Its next value
  logic [15:0]   stat1Sel;   // Address of status one in chosen set
  logic          stat1Other; // Status one of unselected set addressed
  logic          hitS1;      // Status one address match
  dgr_status_if  stIf ();    // Status bytes from gatherer

  // Port match helper used in several decodes
  function automatic logic portIs(input logic [15:0] a,
                                  input logic [15:0] p);
    return a == p;
  endfunction

  // Synchroniser chain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncAReg <= '0;
      syncBReg <= '0;
    end else if (clkEn) begin
      syncAReg <= {data_bus_line_fifteen, vRetraceIrq, vRetraceIn,
                   blankingIn, vidBitsIn};
      syncBReg <= syncAReg;
    end
  end

  // Status gatherer
  dgr_status uStatus (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .clkEn        (clkEn),
    .irqPend      (syncBReg[10]),
    .monLevel     (syncBReg[11]),
    .vRetrace     (syncBReg[9]),
    .blanking     (syncBReg[8]),
    .vidBits      (syncBReg[7:0]),
    .planeDiagSel (planeDiagSel),
    .st           (stIf.source)
  );

  // Address set chosen by bit 0
  always_comb begin
    stat1Sel   = miscReg[MISC_COLOR_IO] ? PORT_STAT1_COL
                                        : PORT_STAT1_MON;
    stat1Other = portIs(ioAddr, miscReg[MISC_COLOR_IO] ? PORT_STAT1_MON
                                                        : PORT_STAT1_COL);
    hitS1      = portIs(ioAddr, stat1Sel);
  end

  // Next values for writes and read data
  always_comb begin
    miscNext = miscReg;
    decNext  = decReg;
    if (ioWr && portIs(ioAddr, PORT_MISC_WR)) begin
      miscNext = ioWrData;
    end
    if (ioWr && portIs(ioAddr, PORT_SUBSYS) && altBusMode) begin
      decNext = ioWrData[SUBSYS_DECODE];
    end
    rdNext  = 8'h00;
    hitNext = 1'b0;
    if (ioRd) begin
      if (portIs(ioAddr, PORT_MISC_RD)) begin
        rdNext  = miscReg;
        hitNext = 1'b1;
      end else if (portIs(ioAddr, PORT_STAT0)) begin
        rdNext  = stIf.statZero;
        hitNext = 1'b1;
      end else if (hitS1) begin
        rdNext  = stIf.statOne;
        hitNext = 1'b1;
      end else if (stat1Other) begin
        rdNext  = 8'h00;  // Unselected status port refused
        hitNext = 1'b0;
      end else begin
        rdNext  = 8'h00;  // All other addresses stay silent
        hitNext = 1'b0;
      end
    end
  end

  // Register state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      miscReg <= MISC_RESET;
      decReg  <= 1'b0;
      rdReg   <= 8'h00;
      hitReg  <= 1'b0;
    end else if (clkEn) begin
      miscReg <= miscNext;
      decReg  <= decNext;
      rdReg   <= rdNext;
      hitReg  <= hitNext;
    end
  end

  // Control outputs from the register, address decodes and straps
  always_comb begin
    vsyncNeg   = miscReg[MISC_VSYNC_POL];
    hsyncNeg   = miscReg[MISC_HSYNC_POL];
    pageUpper  = miscReg[MISC_PAGE];
    hostMemEn  = miscReg[MISC_MEM_EN];
    colorIoSel = miscReg[MISC_COLOR_IO];
    // Higher selections only honoured with config bit 3 clear
    if (configBitThree && miscReg[MISC_CLK_HI:MISC_CLK_LO] != CLK_SEL_A)
      dotClkSel = CLK_SEL_A;
    else if (miscReg[MISC_CLK_HI])
      dotClkSel = 2'b10;
    else
      dotClkSel = miscReg[MISC_CLK_HI:MISC_CLK_LO];
    // Timing ports answer only in the selected set
    crtIndexSel = portIs(ioAddr, miscReg[MISC_COLOR_IO] ? PORT_CRT_IDX_C
                                                     : PORT_CRT_IDX_M);
    crtDataSel  = portIs(ioAddr, miscReg[MISC_COLOR_IO] ? PORT_CRT_DAT_C
                                                     : PORT_CRT_DAT_M);
    decodeEn = altBusMode ? decReg : 1'b1;
    setupSel = !altBusMode && (portIs(ioAddr, PORT_SETUP) ||
               (!config_strap_nine && portIs(ioAddr, PORT_SUBSYS)));
  end

  assign ioRdData = rdReg;
  assign ioRdHit  = hitReg;

  // Write then read back
  sequence s_misc_wr;
    clkEn && ioWr && ioAddr == PORT_MISC_WR;
  endsequence
  a_misc_write: assert property (@(posedge core_clk)
    disable iff (!arst_n) s_misc_wr |=> miscReg == $past(ioWrData))
    else $error("misc write not stored");
  a_misc_read: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    clkEn && ioRd && ioAddr == PORT_MISC_RD |=> ioRdData == $past(miscReg))
    else $error("misc read wrong");
  a_stat_nowrite: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    clkEn && ioWr && ioAddr != PORT_MISC_WR |=> miscReg == $past(miscReg))
    else $error("stray write changed misc");
  a_unsel_silent: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    clkEn && ioRd && ioAddr == (colorIoSel ? PORT_STAT1_MON : PORT_STAT1_COL)
    |=> !ioRdHit) else $error("unselected set answered");
  a_sync_pol: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    vsyncNeg == miscReg[7] && hsyncNeg == miscReg[6])
    else $error("sync polarity mismatch");
  a_mem_gate: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    s_misc_wr ##1 1'b1 |-> hostMemEn == $past(ioWrData[1]))
    else $error("memory gate mismatch");
  a_clk_user: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    !configBitThree && miscReg[3] |-> dotClkSel == 2'b10)
    else $error("user clock not chosen");
  a_decode_en: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    clkEn && altBusMode && ioWr && ioAddr == PORT_SUBSYS ##1 altBusMode
    |-> decodeEn == $past(ioWrData[0]))
    else $error("decode enable mismatch");
  a_irq_status: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    clkEn && ioRd && ioAddr == PORT_STAT0
    |=> ioRdData[7] == $past(stIf.statZero[7]))
    else $error("irq status wrong");
  a_page_sel: assert property (@(posedge core_clk)
    disable iff (!arst_n) pageUpper == miscReg[5])
    else $error("page select mismatch");
endmodule
`default_nettype wire

// ---- design/dgr_pkg.sv ----
package dgr_pkg;
  // Host I/O port addresses
  localparam logic [15:0] PORT_MISC_WR   = 16'h03C2;
  localparam logic [15:0] PORT_MISC_RD   = 16'h03CC;
  localparam logic [15:0] PORT_STAT0     = 16'h03C2;
  localparam logic [15:0] PORT_STAT1_MON = 16'h03BA;
  localparam logic [15:0] PORT_STAT1_COL = 16'h03DA;
  localparam logic [15:0] PORT_CRT_IDX_M = 16'h03B4;
  localparam logic [15:0] PORT_CRT_DAT_M = 16'h03B5;
  localparam logic [15:0] PORT_CRT_IDX_C = 16'h03D4;
  localparam logic [15:0] PORT_CRT_DAT_C = 16'h03D5;
  localparam logic [15:0] PORT_SUBSYS    = 16'h03C3;
  localparam logic [15:0] PORT_SETUP     = 16'h46E8;
  // Miscellaneous output fields
  localparam int MISC_VSYNC_POL = 7;
  localparam int MISC_HSYNC_POL = 6;
  localparam int MISC_PAGE      = 5;
  localparam int MISC_CLK_HI    = 3;
  localparam int MISC_CLK_LO    = 2;
  localparam int MISC_MEM_EN    = 1;
  localparam int MISC_COLOR_IO  = 0;
  localparam logic [7:0] MISC_RESET = 8'h00;
  // Status register 0 fields
  localparam int STAT0_IRQ      = 7;
  localparam int STAT0_MONITOR  = 4;
  // Status register 1 fields
  localparam int STAT1_DIAG_HI  = 5;
  localparam int STAT1_DIAG_LO  = 4;
  localparam int STAT1_VRETRACE = 3;
  localparam int STAT1_BLANK    = 0;
  // Subsystem enable field
  localparam int SUBSYS_DECODE  = 0;
  // Dot clock select codes
  localparam logic [1:0] CLK_SEL_A = 2'b00;
  localparam logic [1:0] CLK_SEL_B = 2'b01;
endpackage

// ---- design/dgr_status_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Carries the two status bytes from the status gatherer to the top
interface dgr_status_if;
  logic [7:0] statZero;  // Input status zero image
  logic [7:0] statOne;   // Input status one image
  modport source (output statZero, output statOne);
  modport sink   (input statZero, input statOne);
endinterface
`default_nettype wire

// ---- design/dgr_status.sv ----
`timescale 1ns/100ps
`default_nettype none
// Gathers synchronised video state into the two status bytes
module dgr_status
  import dgr_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  // Synchronised video state and unsynchronised diagnostic select
  input  wire logic       irqPend,
  input  wire logic       monLevel,
  input  wire logic       vRetrace,
  input  wire logic       blanking,
  input  wire logic [7:0] vidBits,
  input  wire logic [1:0] planeDiagSel,
  // Status bytes out
  dgr_status_if.source    st
);
  logic [7:0] s0Reg;   // Status zero register
  logic [7:0] s0Next;  // Its next value
  logic [7:0] s1Reg;   // Status one register
  logic [7:0] s1Next;  // Its next value
  logic [1:0] diag;    // Selected diagnostic pair

  // Build next status values; reserved bits read zero
  always_comb begin
    unique case (planeDiagSel)
      2'b00: diag = {vidBits[2], vidBits[0]};
      2'b01: diag = {vidBits[5], vidBits[4]};
      2'b10: diag = {vidBits[3], vidBits[1]};
      2'b11: diag = {vidBits[7], vidBits[6]};
    endcase
    s0Next = 8'h00;
    s0Next[STAT0_IRQ] = irqPend;
    s0Next[STAT0_MONITOR] = monLevel;
    s1Next = 8'h00;
    s1Next[STAT1_DIAG_HI] = diag[1];
    s1Next[STAT1_DIAG_LO] = diag[0];
    s1Next[STAT1_VRETRACE] = vRetrace;
    s1Next[STAT1_BLANK] = blanking;
  end

  // Register status bytes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s0Reg <= 8'h00;
      s1Reg <= 8'h00;
    end else if (clkEn) begin
      s0Reg <= s0Next;
      s1Reg <= s1Next;
    end
  end

  assign st.statZero = s0Reg;
  assign st.statOne  = s1Reg;

  // Status one must show retrace one cycle after synced input
  a_vret_status: assert property (@(posedge core_clk)
    disable iff (!arst_n) clkEn |=> s1Reg[STAT1_VRETRACE] == $past(vRetrace))
    else $error("retrace status bit mismatch");
  a_reserved_zero: assert property (@(posedge core_clk)
    disable iff (!arst_n) s1Reg[7:6] == 2'b00 && s1Reg[2:1] == 2'b00)
    else $error("reserved status bits not zero");
endmodule
`default_nettype wire

// ---- verification/dgr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Host processor side: byte I/O cycles with one-cycle strobes
module dgr_host_model (
  // Clock
  input  wire logic        core_clk,
  // Host I/O bus
  output logic      [15:0] ioAddr,
  output logic             ioWr,
  output logic             ioRd,
  output logic      [7:0]  ioWrData
);
  // Idle bus at time zero
  initial begin
    ioAddr = 16'h0000;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWrData = 8'h00;
  end
  // One strobed cycle; released data shows a changed pattern
  task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                     input logic w);
    @(negedge core_clk);
    ioAddr = a;
    ioWrData = d;
    ioWr = w;
    ioRd = ~w;
    @(negedge core_clk);
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWrData = ~d;
  endtask
  // Address only, no strobe
  task automatic park(input logic [15:0] a);
    @(negedge core_clk);
    ioAddr = a;
  endtask
endmodule
`default_nettype wire

// ---- verification/display_general_registers_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module display_general_registers_tb;
  import dgr_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, altMode = 1'b0, strap9 = 1'b0;
  logic cfg3 = 1'b0, mon = 1'b0, irq = 1'b0, vr = 1'b0, bl = 1'b0;
  logic [7:0] vid = 8'h00, rdData, d;
  logic [1:0] diagSel = 2'b00, dclk, dg;
  logic rdPipe = 1'b0, en = 1'b1;
  logic [15:0] addr;
  logic wr, rd, rdHit, vs, hs, pg, me, col, ci, cd, de, su;
  logic [7:0] wd;
  logic [8:0] expQ[$];
  int errTotal = 0, compares = 0;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  dgr_host_model u_dgr_host_model (.core_clk(core_clk), .ioAddr(addr),
    .ioWr(wr), .ioRd(rd), .ioWrData(wd));
  dgr_general_regs u_dgr_general_regs (.core_clk(core_clk),
    .arst_n(arst_n), .clkEn(en), .ioAddr(addr), .ioWr(wr), .ioRd(rd),
    .ioWrData(wd), .ioRdData(rdData), .ioRdHit(rdHit),
    .altBusMode(altMode), .config_strap_nine(strap9),
    .configBitThree(cfg3), .data_bus_line_fifteen(mon),
    .vRetraceIrq(irq), .vRetraceIn(vr), .blankingIn(bl),
    .vidBitsIn(vid), .planeDiagSel(diagSel), .vsyncNeg(vs),
    .hsyncNeg(hs), .pageUpper(pg), .dotClkSel(dclk), .hostMemEn(me),
    .colorIoSel(col), .crtIndexSel(ci), .crtDataSel(cd),
    .decodeEn(de), .setupSel(su));
  // Compare and count
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    compares++;
    if (s !== e) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Read with expected {hit,data} noted first
  task automatic rdx(input logic [15:0] a, input logic [8:0] e);
    expQ.push_back(e);
    u_dgr_host_model.cyc(a, 8'h00, 1'b0);
  endtask
  task automatic complete_run;
    $display("errors=%0d compares=%0d", errTotal, compares);
    if (errTotal == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read answers stand in the cycle after the taking edge
  always @(posedge core_clk) rdPipe <= rd;
  always @(negedge core_clk) begin
    if (rdPipe) begin
      if (expQ.size() == 0) chk({rdHit, rdData}, 9'h1FF);
      else chk({rdHit, rdData}, expQ.pop_front());
    end
  end
  // Hang guard
  initial begin
    #200_000;
    errTotal++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h3921));
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    rdx(PORT_MISC_RD, 9'h100);
    chk({vs, hs, pg, me, col, dclk}, 9'h000);
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      d = {2'(1 + $urandom % 3), 1'($urandom), 1'b0, 2'(i % 4),
           2'($urandom)};
      cfg3 = 1'($urandom);
      {irq, mon, vr, bl} = 4'($urandom);
      vid = 8'($urandom);
      diagSel = 2'(i % 4);
      u_dgr_host_model.cyc(PORT_MISC_WR, d, 1'b1);
      @(negedge core_clk);
      dg = (d[3:2] == 2'b00 || cfg3) ? CLK_SEL_A :
           (d[3:2] == 2'b01) ? CLK_SEL_B : 2'b10;
      chk({vs, hs, pg, me, col, dclk}, {1'b0, d[7:5], d[1:0], dg});
      u_dgr_host_model.cyc(d[0] ? PORT_STAT1_COL : PORT_STAT1_MON, ~d,
                           1'b1);
      rdx(PORT_MISC_RD, {1'b1, d});
      repeat (4) @(negedge core_clk);
      rdx(PORT_STAT0, {1'b1, irq, 2'b00, mon, 4'h0});
      case (diagSel)
        2'b00: dg = {vid[2], vid[0]};
        2'b01: dg = {vid[5], vid[4]};
        2'b10: dg = {vid[3], vid[1]};
        default: dg = {vid[7], vid[6]};
      endcase
      rdx(d[0] ? PORT_STAT1_COL : PORT_STAT1_MON,
          {3'b100, dg, vr, 2'b00, bl});
      rdx(d[0] ? PORT_STAT1_MON : PORT_STAT1_COL, 9'h000);
      u_dgr_host_model.park(d[0] ? PORT_CRT_IDX_C : PORT_CRT_IDX_M);
      #1 chk({7'h00, ci, cd}, 9'h002);
      u_dgr_host_model.park(d[0] ? PORT_CRT_DAT_C : PORT_CRT_DAT_M);
      #1 chk({7'h00, ci, cd}, 9'h001);
      u_dgr_host_model.park(d[0] ? PORT_CRT_DAT_M : PORT_CRT_DAT_C);
      #1 chk({7'h00, ci, cd}, 9'h000);
    end
    // Frozen enable: a write must not land
    @(negedge core_clk);
    en = 1'b0;
    u_dgr_host_model.cyc(PORT_MISC_WR, d ^ 8'h2E, 1'b1);
    @(negedge core_clk);
    en = 1'b1;
    rdx(PORT_MISC_RD, {1'b1, d});
    // Reset in mid-run returns the register to zero
    @(negedge core_clk);
    arst_n = 1'b0;
    @(negedge core_clk);
    arst_n = 1'b1;
    rdx(PORT_MISC_RD, 9'h100);
    chk({vs, hs, pg, me, col, dclk}, 9'h000);
    @(negedge core_clk);
    altMode = 1'b1;
    for (int v = 1; v >= 0; v--) begin
      u_dgr_host_model.cyc(PORT_SUBSYS, 8'(v), 1'b1);
      @(negedge core_clk);
      chk({8'h00, de}, 9'(v));
    end
    altMode = 1'b0;
    u_dgr_host_model.cyc(PORT_SUBSYS, 8'h01, 1'b1);
    u_dgr_host_model.park(PORT_SETUP);
    #1 chk({7'h00, de, su}, 9'h003);
    u_dgr_host_model.park(PORT_SUBSYS);
    #1 chk({8'h00, su}, 9'h001);
    @(negedge core_clk);
    strap9 = 1'b1;
    #1 chk({8'h00, su}, 9'h000);
    @(negedge core_clk);
    altMode = 1'b1;
    #1 chk({8'h00, de}, 9'h000);
    for (int k = 0; k < 10 && expQ.size() > 0; k++) @(negedge core_clk);
    if (expQ.size() > 0) errTotal++;
    complete_run();
  end
endmodule
`default_nettype wire
